// ### rtl/qpi_pkg.sv
// Constants, types and reset values for the quad port pin interface.
// Assumes a 100 MHz core clock and a host serial clock on host pin one.
package qpi_pkg;

  localparam int CLK_PERIOD_NS = 10;
  // Settling time after enable before the host bus is served
  localparam int POR_WAIT_NS = 20000;
  localparam int POR_CYCLES = (POR_WAIT_NS + CLK_PERIOD_NS - 1) /
                              CLK_PERIOD_NS;
  localparam int EN_HOLD_NS = 12500;
  // Half period of the shared LED timing clock, in core cycles
  localparam int LED_HALF_CYCLES = 500;
  localparam int CNT_W = 16;
  localparam int NPORT = 4;
  localparam int NSTAT = 12;
  localparam int SPI_BITS = 8;

  localparam logic [3:0] OUT_A_LVL_RST = 4'hF;
  localparam logic [3:0] OUT_A_OE_RST = 4'h0;
  localparam logic [3:0] OUT_B_LVL_RST = 4'h0;
  localparam logic [3:0] OUT_B_OE_RST = 4'h0;
  localparam logic [3:0] OUT_CD_LVL_RST = 4'hF;
  localparam logic [3:0] OUT_CD_OE_RST = 4'hF;
  localparam logic [3:0] GPIO_OE_RST = 4'h0;
  localparam logic [3:0] GPIO_LVL_RST = 4'h0;

  typedef enum logic [1:0] {
    QPI_PWR_OFF = 2'b00,
    QPI_PWR_WAIT = 2'b01,
    QPI_PWR_ON = 2'b10
  } qpi_pwr_e;

  // Level and output enable for the four control output groups
  typedef struct packed {
    logic [3:0] a_lvl;
    logic [3:0] a_oe;
    logic [3:0] b_lvl;
    logic [3:0] b_oe;
    logic [3:0] c_lvl;
    logic [3:0] c_oe;
    logic [3:0] d_lvl;
    logic [3:0] d_oe;
  } qpi_ctl_out_s;

  // Open-drain pull-low enables of the module I2C lines
  typedef struct packed {
    logic [3:0] scl_oe;
    logic [3:0] sda_oe;
  } qpi_mod_od_s;

  // Status inputs grouped A, B, C; one bit per port
  typedef struct packed {
    logic [3:0] c;
    logic [3:0] b;
    logic [3:0] a;
  } qpi_stat_s;

  // Status and active-low host pins idle high through their pull-ups
  localparam qpi_stat_s STAT_IDLE_RST = '{c: 4'hF, b: 4'hF, a: 4'hF};
  localparam logic PIN_IDLE_RST = 1'b1;

endpackage

// ### rtl/qpi_top.sv
// Pin-level core of a four-port low-speed signal aggregator.
// Assumes pins are resolved outside from the output enables; host pin one
// clocks the SPI shifter and is otherwise free to stop between frames.
`timescale 1ns/100ps

module qpi_top #(
  parameter int POR_WAIT_CYCLES = qpi_pkg::POR_CYCLES,
  parameter int LED_HALF = qpi_pkg::LED_HALF_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic en_pin,
  input wire logic host_iface_select,
  input wire logic host_pin_one_in,
  output logic host_pin_one_o,
  output logic host_pin_one_oe,
  input wire logic host_pin_two_in,
  output logic host_pin_two_o,
  output logic host_pin_two_oe,
  input wire logic host_pin_three_in,
  output logic host_pin_four_o,
  output logic host_pin_four_oe,
  input wire logic led_timing_share_pin_in,
  output logic led_timing_share_pin_o,
  output logic led_timing_share_pin_oe,
  output logic host_int_n_o,
  output logic host_int_n_oe,
  input wire qpi_pkg::qpi_stat_s stat_in,
  input wire logic [3:0] mod_scl_in,
  input wire logic [3:0] mod_sda_in,
  output qpi_pkg::qpi_mod_od_s mod_od,
  input wire logic [3:0] gpio_in,
  output logic [3:0] gpio_o,
  output logic [3:0] gpio_oe,
  output qpi_pkg::qpi_ctl_out_s ctl_out,
  input wire logic host_scl_pull,
  input wire logic host_sda_pull,
  input wire logic addr_done,
  input wire logic led_src,
  input wire logic [3:0] mod_scl_pull,
  input wire logic [3:0] mod_sda_pull,
  input wire logic gpio_cfg_wr,
  input wire logic [3:0] gpio_oe_cfg,
  input wire logic [3:0] gpio_lvl_cfg,
  input wire logic out_cfg_wr,
  input wire qpi_pkg::qpi_ctl_out_s out_cfg,
  input wire logic [qpi_pkg::NSTAT-1:0] int_mask,
  input wire logic [qpi_pkg::NSTAT-1:0] int_clear,
  output logic [qpi_pkg::NSTAT-1:0] int_pending,
  output qpi_pkg::qpi_stat_s stat_level,
  output logic [3:0] mod_scl_level,
  output logic [3:0] mod_sda_level,
  output logic [3:0] gpio_level,
  output logic host_scl_level,
  output logic host_sda_level,
  output logic spi_mode,
  output logic device_ready,
  output logic set_addr_req,
  output logic [7:0] spi_rx_data,
  output logic spi_rx_valid,
  output logic led_tick
);
  import qpi_pkg::*;

  if (POR_WAIT_CYCLES < 1 || POR_WAIT_CYCLES >= (1 << CNT_W) ||
      LED_HALF < 1 || LED_HALF >= (1 << CNT_W)) begin : g_bad_param
    $error("POR_WAIT_CYCLES or LED_HALF out of range");
  end

  localparam logic [CNT_W-1:0] POR_LAST = CNT_W'(POR_WAIT_CYCLES - 1);
  localparam logic [CNT_W-1:0] LED_LAST = CNT_W'(LED_HALF - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Core clock state

  typedef struct packed {
    logic sel_s1;
    logic sel_s2;
    logic en_s1;
    logic en_s2;
    logic p1_s1;
    logic p1_s2;
    logic p2_s1;
    logic p2_s2;
    logic p3_s1;
    logic p3_s2;
    logic p3_s3;
    logic led_s1;
    logic led_s2;
    logic led_s3;
    qpi_stat_s stat_s1;
    qpi_stat_s stat_s2;
    qpi_stat_s stat_s3;
    logic [3:0] mscl_s1;
    logic [3:0] mscl_s2;
    logic [3:0] msda_s1;
    logic [3:0] msda_s2;
    logic [3:0] gpio_s1;
    logic [3:0] gpio_s2;
    logic rxt_s1;
    logic rxt_s2;
    logic rxt_s3;
    qpi_pwr_e pwr;
    logic [CNT_W-1:0] por_cnt;
    qpi_ctl_out_s ctl;
    logic [3:0] gpio_oe;
    logic [3:0] gpio_lvl;
    logic [NSTAT-1:0] pend;
    logic [7:0] rx_data;
    logic rx_valid;
    logic [CNT_W-1:0] led_cnt;
    logic led_clk;
    logic tick;
    logic set_addr;
    qpi_mod_od_s mod_od;
    logic host_scl_oe;
    logic host_sda_oe;
  } qpi_core_s;

  localparam qpi_core_s CORE_RST = '{
    pwr: QPI_PWR_OFF,
    p3_s1: PIN_IDLE_RST, p3_s2: PIN_IDLE_RST, p3_s3: PIN_IDLE_RST,
    led_s1: PIN_IDLE_RST, led_s2: PIN_IDLE_RST, led_s3: PIN_IDLE_RST,
    stat_s1: STAT_IDLE_RST, stat_s2: STAT_IDLE_RST, stat_s3: STAT_IDLE_RST,
    ctl: '{a_lvl: OUT_A_LVL_RST, a_oe: OUT_A_OE_RST,
           b_lvl: OUT_B_LVL_RST, b_oe: OUT_B_OE_RST,
           c_lvl: OUT_CD_LVL_RST, c_oe: OUT_CD_OE_RST,
           d_lvl: OUT_CD_LVL_RST, d_oe: OUT_CD_OE_RST},
    gpio_oe: GPIO_OE_RST,
    gpio_lvl: GPIO_LVL_RST,
    default: '0
  };

  qpi_core_s core_reg;
  qpi_core_s core_next;

  ////////////////////////////////////////////////////////////////////////////
  // Link clock state: SPI shifter on host pin one

  typedef struct packed {
    logic [7:0] sh;
    logic [7:0] rx_byte;
    logic rx_tgl;
    logic [7:0] tx;
  } qpi_link_s;

  qpi_link_s link_reg;
  qpi_link_s link_next;
  logic [2:0] bit_cnt_reg;
  logic frame_clr;

  // Deselect ends the frame, so a partial byte never reaches the core
  assign frame_clr = reset | host_pin_two_in;

  always_ff @(posedge host_pin_one_in or posedge frame_clr) begin
    if (frame_clr) begin
      bit_cnt_reg <= 3'h0;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
    end
  end

  always_comb begin
    link_next = link_reg;
    link_next.sh = {link_reg.sh[6:0], host_pin_three_in};
    link_next.tx = {link_reg.tx[6:0], 1'b0};
    if (bit_cnt_reg == 3'(SPI_BITS - 1)) begin
      link_next.rx_byte = {link_reg.sh[6:0], host_pin_three_in};
      link_next.rx_tgl = ~link_reg.rx_tgl;
      // Next byte shifted out echoes the byte just received
      link_next.tx = {link_reg.sh[6:0], host_pin_three_in};
    end
  end

  always_ff @(posedge host_pin_one_in or posedge reset) begin
    if (reset) begin
      link_reg <= '0;
    end else begin
      link_reg <= link_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core next state

  always_comb begin
    logic is_spi;
    logic ready;
    logic in_rise;
    logic wrap;
    logic [NSTAT-1:0] evt;
    is_spi = 1'b0;
    ready = 1'b0;
    in_rise = 1'b0;
    wrap = 1'b0;
    evt = '0;
    core_next = core_reg;
    core_next.sel_s1 = host_iface_select;
    core_next.sel_s2 = core_reg.sel_s1;
    core_next.en_s1 = en_pin;
    core_next.en_s2 = core_reg.en_s1;
    core_next.p1_s1 = host_pin_one_in;
    core_next.p1_s2 = core_reg.p1_s1;
    core_next.p2_s1 = host_pin_two_in;
    core_next.p2_s2 = core_reg.p2_s1;
    core_next.p3_s1 = host_pin_three_in;
    core_next.p3_s2 = core_reg.p3_s1;
    core_next.p3_s3 = core_reg.p3_s2;
    core_next.led_s1 = led_timing_share_pin_in;
    core_next.led_s2 = core_reg.led_s1;
    core_next.led_s3 = core_reg.led_s2;
    core_next.stat_s1 = stat_in;
    core_next.stat_s2 = core_reg.stat_s1;
    core_next.stat_s3 = core_reg.stat_s2;
    core_next.mscl_s1 = mod_scl_in;
    core_next.mscl_s2 = core_reg.mscl_s1;
    core_next.msda_s1 = mod_sda_in;
    core_next.msda_s2 = core_reg.msda_s1;
    core_next.gpio_s1 = gpio_in;
    core_next.gpio_s2 = core_reg.gpio_s1;
    core_next.rxt_s1 = link_reg.rx_tgl;
    core_next.rxt_s2 = core_reg.rxt_s1;
    core_next.rxt_s3 = core_reg.rxt_s2;
    is_spi = ~core_reg.sel_s2;
    ready = (core_reg.pwr == QPI_PWR_ON);
    // Power sequencing after the enable pin
    case (core_reg.pwr)
      QPI_PWR_OFF: begin
        core_next.por_cnt = '0;
        if (core_reg.en_s2) begin
          core_next.pwr = QPI_PWR_WAIT;
        end
      end
      QPI_PWR_WAIT: begin
        core_next.por_cnt = core_reg.por_cnt + CNT_W'(1);
        if (!core_reg.en_s2) begin
          core_next.pwr = QPI_PWR_OFF;
        end else if (core_reg.por_cnt == POR_LAST) begin
          core_next.pwr = QPI_PWR_ON;
        end
      end
      QPI_PWR_ON: begin
        if (!core_reg.en_s2) begin
          core_next.pwr = QPI_PWR_OFF;
        end
      end
      default: begin
        core_next.pwr = QPI_PWR_OFF;
      end
    endcase
    // Received SPI byte crosses by toggle; dropped unless served
    core_next.rx_valid = 1'b0;
    if ((core_reg.rxt_s2 != core_reg.rxt_s3) && is_spi && ready) begin
      core_next.rx_data = link_reg.rx_byte;
      core_next.rx_valid = 1'b1;
    end
    // Host I2C open-drain pulls only when served
    core_next.host_scl_oe = host_scl_pull & ~is_spi & ready;
    core_next.host_sda_oe = host_sda_pull & ~is_spi & ready;
    core_next.set_addr = ~core_reg.p3_s2 & ~is_spi & ready;
    // Module I2C links start nothing while disabled
    core_next.mod_od.scl_oe = mod_scl_pull & {NPORT{ready}};
    core_next.mod_od.sda_oe = mod_sda_pull & {NPORT{ready}};
    if (gpio_cfg_wr) begin
      core_next.gpio_oe = gpio_oe_cfg;
      core_next.gpio_lvl = gpio_lvl_cfg;
    end
    if (out_cfg_wr) begin
      core_next.ctl = out_cfg;
    end
    // Status changes latch; a new event wins over its clear
    evt = (core_reg.stat_s2 ^ core_reg.stat_s3) & int_mask;
    core_next.pend = (core_reg.pend & ~int_clear) | evt;
    // LED timing: own divider as source, else follow the incoming clock
    wrap = (core_reg.led_cnt == LED_LAST);
    core_next.led_cnt = wrap ? '0 : core_reg.led_cnt + CNT_W'(1);
    core_next.led_clk = core_reg.led_clk ^ wrap;
    in_rise = is_spi ? (core_reg.led_s2 & ~core_reg.led_s3)
                     : (core_reg.p3_s2 & ~core_reg.p3_s3);
    core_next.tick = led_src ? (wrap & ~core_reg.led_clk) : in_rise;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      core_reg <= CORE_RST;
    end else begin
      core_reg <= core_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins and user outputs

  assign spi_mode = ~core_reg.sel_s2;
  assign device_ready = (core_reg.pwr == QPI_PWR_ON);

  assign host_pin_one_o = 1'b0;
  assign host_pin_one_oe = core_reg.host_scl_oe;
  assign host_pin_two_o = 1'b0;
  assign host_pin_two_oe = core_reg.host_sda_oe;
  // MISO while selected in SPI mode; done flag or LED clock in I2C mode
  always_comb begin
    if (spi_mode) begin
      host_pin_four_o = link_reg.tx[7];
      host_pin_four_oe = ~host_pin_two_in & device_ready;
    end else begin
      host_pin_four_o = addr_done ? (led_src & core_reg.led_clk)
                                  : 1'b1;
      host_pin_four_oe = 1'b1;
    end
  end
  assign led_timing_share_pin_o = core_reg.led_clk;
  assign led_timing_share_pin_oe = spi_mode & led_src;
  assign host_int_n_o = 1'b0;
  assign host_int_n_oe = |core_reg.pend;
  assign mod_od = core_reg.mod_od;
  assign gpio_o = core_reg.gpio_lvl;
  assign gpio_oe = core_reg.gpio_oe;
  assign ctl_out = core_reg.ctl;
  assign int_pending = core_reg.pend;
  assign stat_level = core_reg.stat_s2;
  assign mod_scl_level = core_reg.mscl_s2;
  assign mod_sda_level = core_reg.msda_s2;
  assign gpio_level = core_reg.gpio_s2;
  assign host_scl_level = core_reg.p1_s2;
  assign host_sda_level = core_reg.p2_s2;
  assign set_addr_req = core_reg.set_addr;
  assign spi_rx_data = core_reg.rx_data;
  assign spi_rx_valid = core_reg.rx_valid;
  assign led_tick = core_reg.tick;

endmodule // qpi_top

// ### dv/qpi_top_asserts.sv
// Assertions on the ports of qpi_top.
// Assumes one clk domain with asynchronous active-high reset.
`timescale 1ns/100ps
module qpi_top_chk #(
  parameter int POR_WAIT_CYCLES = 10
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic en_pin,
  input wire logic host_pin_one_o,
  input wire logic host_pin_one_oe,
  input wire logic host_pin_two_o,
  input wire logic host_int_n_o,
  input wire logic host_int_n_oe,
  input wire qpi_pkg::qpi_mod_od_s mod_od,
  input wire logic [3:0] gpio_o,
  input wire logic [3:0] gpio_oe,
  input wire qpi_pkg::qpi_ctl_out_s ctl_out,
  input wire logic host_scl_pull,
  input wire logic [3:0] mod_scl_pull,
  input wire logic [3:0] mod_sda_pull,
  input wire logic gpio_cfg_wr,
  input wire logic out_cfg_wr,
  input wire qpi_pkg::qpi_ctl_out_s out_cfg,
  input wire logic [qpi_pkg::NSTAT-1:0] int_mask,
  input wire logic [qpi_pkg::NSTAT-1:0] int_pending,
  input wire logic spi_mode,
  input wire logic device_ready,
  input wire logic spi_rx_valid
);
  import qpi_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Cycles the enable pin has been high without a break
  logic [15:0] en_cnt_reg;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      en_cnt_reg <= 16'h0;
    end else if (!en_pin) begin
      en_cnt_reg <= 16'h0;
    end else if (en_cnt_reg != 16'hFFFF) begin
      en_cnt_reg <= en_cnt_reg + 16'h1;
    end
  end
  ////////////////////////////////////////////////////////////
  od_low_a: assert property (!host_int_n_o && !host_pin_one_o
    && !host_pin_two_o) else $error("open-drain level high");
  int_pin_a: assert property (host_int_n_oe == |int_pending)
    else $error("interrupt pin disagrees with pending");
  int_mask_a: assert property (1 |=> (int_pending &
    ~$past(int_pending) & ~$past(int_mask)) == '0) else $error("masked set");
  mod_od_a: assert property (1 |=> mod_od == ($past({mod_scl_pull,
    mod_sda_pull}) & {8{$past(device_ready)}})) else $error("module od");
  en_off_a: assert property ((!en_pin)[*4] |-> !device_ready)
    else $error("ready while disabled");
  por_a: assert property ($rose(device_ready) |->
    en_cnt_reg > POR_WAIT_CYCLES) else $error("ready too early");
  rx_ok_a: assert property (spi_rx_valid |->
    $past(spi_mode && device_ready))
    else $error("byte taken while not serving");
  gpio_hold_a: assert property (!gpio_cfg_wr |=> $stable(gpio_oe) &&
    $stable(gpio_o)) else $error("gpio changed unasked");
  cfg_load_a: assert property (out_cfg_wr |=>
    ctl_out == $past(out_cfg)) else $error("output config not loaded");
  scl_i2c_a: assert property (host_pin_one_oe |->
    $past(host_scl_pull && !spi_mode && device_ready)) else $error("scl");
endmodule // qpi_top_chk

bind qpi_top qpi_top_chk #(.POR_WAIT_CYCLES(POR_WAIT_CYCLES)) i_chk (
  .clk, .reset, .en_pin, .host_pin_one_o, .host_pin_one_oe,
  .host_pin_two_o, .host_int_n_o, .host_int_n_oe, .mod_od, .gpio_o,
  .gpio_oe, .ctl_out, .host_scl_pull, .mod_scl_pull, .mod_sda_pull,
  .gpio_cfg_wr, .out_cfg_wr, .out_cfg, .int_mask, .int_pending,
  .spi_mode, .device_ready, .spi_rx_valid
);

// ### dv/qpi_host_model.sv
// Host controller model driving the shared pins as an SPI master.
// Assumes its 30 ns serial clock stands low between frames.
`timescale 1ns/100ps
module qpi_host_model (
  output logic sck,
  output logic ss_n,
  output logic mosi,
  input wire logic miso
);
  initial begin
    sck = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b1;
  end
  task automatic sel_on();
    ss_n = 1'b0;
    #20;
  endtask
  task automatic sel_off();
    #20;
    ss_n = 1'b1;
    mosi = ~mosi;
  endtask
  // One byte MSB first; MISO taken just before each rising edge
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi = tx[i];
      #15;
      rx[i] = miso;
      sck = 1'b1;
      #15;
      sck = 1'b0;
    end
  endtask
endmodule // qpi_host_model

// ### dv/test_qpi_top.sv
// Self-checking bench for qpi_top with an SPI host model.
// Assumes a 100 MHz clk and shortened settling and LED counts.
`timescale 1ns/100ps
module test_qpi_top;
  import qpi_pkg::*;
  localparam int POR = 10;
  localparam int LED = 4;
  logic clk, reset, en_pin, host_iface_select, host_scl_pull, addr_done;
  logic gpio_cfg_wr, out_cfg_wr, sck, ss_n, mosi;
  logic host_pin_one_oe, host_pin_four_o, host_pin_four_oe, host_int_n_oe;
  logic device_ready, spi_rx_valid, led_src, led_tick;
  logic led_timing_share_pin_o, led_timing_share_pin_oe;
  logic [3:0] pull4, gpio_oe_cfg, gpio_lvl_cfg, gpio_o, gpio_oe;
  logic [7:0] spi_rx_data;
  logic [11:0] int_mask, int_clear, int_pending;
  qpi_stat_s stat_in;
  qpi_mod_od_s mod_od;
  qpi_ctl_out_s ctl_out, out_cfg;
  logic [7:0] rxq[$];
  int checks, err_count, cycles;

  qpi_top #(.POR_WAIT_CYCLES(POR), .LED_HALF(LED)) i_dut (
    .clk, .reset, .en_pin, .host_iface_select,
    .host_pin_one_in(host_iface_select ? ~host_pin_one_oe : sck),
    .host_pin_one_o(), .host_pin_one_oe, .host_pin_two_in(ss_n),
    .host_pin_two_o(), .host_pin_two_oe(), .host_pin_three_in(mosi),
    .host_pin_four_o, .host_pin_four_oe, .led_timing_share_pin_o,
    .led_timing_share_pin_in(led_timing_share_pin_o |
      ~led_timing_share_pin_oe), .led_timing_share_pin_oe,
    .host_int_n_o(), .host_int_n_oe, .stat_in,
    .mod_scl_in(~mod_od.scl_oe), .mod_sda_in(~mod_od.sda_oe), .mod_od,
    .gpio_in(gpio_o | ~gpio_oe), .gpio_o, .gpio_oe, .ctl_out,
    .host_scl_pull, .host_sda_pull(1'b0), .addr_done, .led_src,
    .mod_scl_pull(pull4), .mod_sda_pull(~pull4), .gpio_cfg_wr,
    .gpio_oe_cfg, .gpio_lvl_cfg, .out_cfg_wr, .out_cfg, .int_mask,
    .int_clear, .int_pending, .stat_level(), .mod_scl_level(),
    .mod_sda_level(), .gpio_level(), .host_scl_level(), .host_sda_level(),
    .spi_mode(), .device_ready, .set_addr_req(), .spi_rx_data,
    .spi_rx_valid, .led_tick
  );
  // An undriven MISO shows the inverse of the last value
  qpi_host_model i_host (.sck, .ss_n, .mosi,
    .miso(host_pin_four_oe ? host_pin_four_o : ~host_pin_four_o));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Sampled mid-cycle, where the one-cycle pulses stand settled
  always @(negedge clk) begin
    cycles++;
    if (spi_rx_valid === 1'b1) begin
      rxq.push_back(spi_rx_data);
    end
    if (cycles == 6000) begin
      err_count++;
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic t_power();
    en_pin = 1'b1;
    // Two sync stages, one cycle to enter the wait, then POR wait cycles
    step(POR + 2);
    chk(device_ready === 1'b0, "ready early");
    step(1);
    chk(device_ready === 1'b1, "never ready");
  endtask
  task automatic t_spi(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] r;
    rxq = {};
    i_host.sel_on();
    i_host.xfer(a, r);
    i_host.xfer(b, r);
    i_host.sel_off();
    step(8);
    if (en_pin) begin
      chk(r === a && rxq.size() == 2, "spi frame");
      chk(rxq[0] === a && rxq[1] === b, "spi data");
    end else begin
      chk(rxq.size() == 0 && mod_od === 8'h00, "active while off");
    end
    chk(host_pin_four_oe === 1'b0, "miso held");
  endtask
  task automatic t_int();
    int_mask = 12'h001;
    step(2);
    stat_in.a[0] = 1'b0;
    step(8);
    chk(int_pending === 12'h001 && host_int_n_oe === 1'b1, "int");
    stat_in.a[1] = 1'b0;
    step(8);
    chk(int_pending === 12'h001, "masked event");
    int_clear = 12'h001;
    step(1);
    int_clear = 12'h000;
    step(1);
    chk(int_pending === 12'h0 && host_int_n_oe === 1'b0, "clear");
  endtask
  task automatic t_cfg();
    out_cfg = {4'hF, 4'hF, 4'h0, 4'hF, 4'h5, 4'hF, 4'hA, 4'h0};
    {out_cfg_wr, gpio_cfg_wr, gpio_oe_cfg, gpio_lvl_cfg} = 10'h3C9;
    step(1);
    chk(ctl_out === out_cfg, "ctl load");
    chk(gpio_oe === 4'hC && gpio_o === 4'h9, "gpio load");
    {out_cfg_wr, gpio_cfg_wr} = 2'b00;
    pull4 = 4'h6;
    step(2);
    chk(mod_od === 8'h69, "module pull");
    pull4 = 4'h0;
  endtask
  task automatic t_led();
    int ticks = 0;
    int flips = 0;
    logic last;
    led_src = 1'b1;
    step(2);
    chk(led_timing_share_pin_oe === 1'b1, "led share drive");
    last = led_timing_share_pin_o;
    // Period of 2 * LED cycles: two ticks and four flips in 4 * LED
    for (int i = 0; i < 4 * LED; i++) begin
      step(1);
      ticks += (led_tick === 1'b1);
      flips += (led_timing_share_pin_o !== last);
      last = led_timing_share_pin_o;
    end
    chk(ticks == 2 && flips == 4, "led timing");
    led_src = 1'b0;
    step(1);
    chk(led_timing_share_pin_oe === 1'b0, "led share free");
  endtask
  task automatic t_i2c();
    host_iface_select = 1'b1;
    step(4);
    chk(host_pin_four_o === 1'b1 && host_pin_four_oe === 1'b1, "busy");
    {host_scl_pull, addr_done} = 2'b11;
    step(3);
    chk(host_pin_one_oe === 1'b1, "scl pull");
    chk(host_pin_four_o === 1'b0, "done flag");
  endtask

  initial begin
    {reset, en_pin, host_iface_select, host_scl_pull, addr_done} = 5'h10;
    led_src = 1'b0;
    {gpio_cfg_wr, out_cfg_wr, pull4, gpio_oe_cfg, gpio_lvl_cfg} = '0;
    {int_mask, int_clear, out_cfg} = '0;
    stat_in = 12'hFFF;
    step(12);
    reset = 1'b0;
    step(2);
    chk(gpio_oe === 4'h0 && host_int_n_oe === 1'b0, "reset pins");
    chk(ctl_out === 32'hF000FFFF, "reset outputs");
    t_power();
    t_spi(8'hA5, 8'h3C);
    t_int();
    t_cfg();
    en_pin = 1'b0;
    step(1250);
    pull4 = 4'hF;
    t_spi(8'h5A, 8'hC3);
    pull4 = 4'h0;
    step(1250);
    t_power();
    t_led();
    t_i2c();
    give_verdict();
  end
endmodule // test_qpi_top
